/* hdl/acs_pkg.sv */
package acs_pkg;
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
   localparam int unsigned DLY_STEP_MS  = 2;
   localparam int unsigned DLY_STEP_CYC = DLY_STEP_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W        = 24;
   localparam int unsigned DATA_W       = 16;
   localparam int unsigned NSAMP_W      = 11;

   localparam logic [5:0] OFS_ADC_CFG = 6'h00;
   localparam logic [5:0] OFS_DEV_CFG = 6'h04;
   localparam logic [5:0] OFS_DIAG    = 6'h08;
   localparam logic [5:0] OFS_TEMP    = 6'h0c;
   localparam logic [5:0] OFS_CURR    = 6'h10;
   localparam logic [5:0] OFS_BUS     = 6'h14;
   localparam logic [5:0] OFS_POWER   = 6'h18;
   localparam logic [5:0] OFS_ENERGY  = 6'h1c;
   localparam logic [5:0] OFS_CHARGE  = 6'h20;

   localparam int unsigned MODE_LSB      = 0;
   localparam int unsigned BUS_CT_LSB    = 3;
   localparam int unsigned SH_CT_LSB     = 6;
   localparam int unsigned TMP_CT_LSB    = 9;
   localparam int unsigned AVG_LSB       = 12;
   localparam int unsigned MODE_CUR_BIT  = 0;
   localparam int unsigned MODE_BUS_BIT  = 1;
   localparam int unsigned MODE_CONT_BIT = 2;
   localparam int unsigned DIAG_RDY_BIT  = 0;
   localparam int unsigned DIAG_BUSY_BIT = 1;
   localparam int unsigned DIAG_ACCV_BIT = 2;

   localparam logic [15:0] ADC_CFG_RST = 16'h0b6f;
   localparam logic [7:0]  DLY_RST     = 8'h00;

   localparam logic [1:0] AFE_SEL_TEMP = 2'h0;
   localparam logic [1:0] AFE_SEL_SH   = 2'h1;
   localparam logic [1:0] AFE_SEL_BUS  = 2'h2;

   typedef enum logic [2:0] {
      ST_SHDN,
      ST_DELAY,
      ST_TEMP,
      ST_SHUNT,
      ST_BUS,
      ST_END
   } acs_state_t;

   function automatic logic [12:0] conv_us(input logic [2:0] code);
      case (code)
         3'h0:    conv_us = 13'd50;
         3'h1:    conv_us = 13'd84;
         3'h2:    conv_us = 13'd150;
         3'h3:    conv_us = 13'd280;
         3'h4:    conv_us = 13'd540;
         3'h5:    conv_us = 13'd1052;
         3'h6:    conv_us = 13'd2074;
         default: conv_us = 13'd4120;
      endcase
   endfunction

   // Sample counts are all powers of two, so the mean is a shift
   function automatic logic [3:0] avg_shift(input logic [2:0] code);
      case (code)
         3'h0:    avg_shift = 4'h0;
         3'h1:    avg_shift = 4'h2;
         3'h2:    avg_shift = 4'h4;
         3'h3:    avg_shift = 4'h6;
         3'h4:    avg_shift = 4'h7;
         3'h5:    avg_shift = 4'h8;
         3'h6:    avg_shift = 4'h9;
         default: avg_shift = 4'ha;
      endcase
   endfunction
endpackage

/* hdl/acs_timer.sv */
`timescale 1ns/1ps
module acs_timer #(
   parameter int unsigned W = 24
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] count_i,
   output logic              busy_o,
   output logic              done_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         busy;
   } acs_tmr_st_t;

   acs_tmr_st_t s_r;
   acs_tmr_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (load_i) begin
         // A zero count still lasts one cycle
         s_nxt.cnt  = (count_i == '0) ? W'(1) : count_i;
         s_nxt.busy = 1'b1;
      end else if (s_r.busy) begin
         s_nxt.cnt  = s_r.cnt - W'(1);
         s_nxt.busy = (s_r.cnt != W'(1));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy_o = s_r.busy;
   assign done_o = s_r.busy && (s_r.cnt == W'(1));
endmodule

/* hdl/acs_avg.sv */
`timescale 1ns/1ps
module acs_avg #(
   parameter int unsigned DW    = 16,
   parameter int unsigned SUM_W = 26
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 clr_i,
   input  wire logic                 add_i,
   input  wire logic signed [DW-1:0] data_i,
   input  wire logic [3:0]           shift_i,
   output logic signed [DW-1:0]      avg_o
);
   typedef struct packed {
      logic signed [SUM_W-1:0] sum;
   } acs_avg_st_t;

   acs_avg_st_t s_r;
   acs_avg_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (clr_i) begin
         s_nxt.sum = '0;
      end
      // A sample landing with the clear starts the new sum
      if (add_i) begin
         s_nxt.sum = s_nxt.sum + SUM_W'(data_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign avg_o = DW'(s_r.sum >>> shift_i);
endmodule

/* hdl/acs_seq.sv */
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module acs_seq #(
   parameter int unsigned CYC_PER_US_P = acs_pkg::CYC_PER_US,
   parameter int unsigned DLY_STEP_P   = acs_pkg::DLY_STEP_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [15:0] afe_data_i,
   output logic [1:0]       afe_sel_o,
   output logic [2:0]       afe_period_o,
   output logic             afe_run_o,
   output logic             afe_shdn_o,
   output logic             conversion_ready_flag_o,
   output logic             acc_valid_o
);
   localparam int unsigned CW = acs_pkg::CNT_W;
   localparam int unsigned DW = acs_pkg::DATA_W;
   localparam int unsigned NW = acs_pkg::NSAMP_W;

   typedef struct packed {
      acs_pkg::acs_state_t st;
      logic [15:0]         adc_cfg;
      logic [7:0]          dly;
      logic                ready;
      logic                acc_valid;
      logic [NW-1:0]       nsamp;
      logic signed [15:0]  temp;
      logic signed [15:0]  curr;
      logic signed [15:0]  bus;
      logic signed [31:0]  power;
      logic signed [31:0]  energy;
      logic signed [31:0]  charge;
      logic                ack;
      logic [31:0]         rdat;
   } acs_seq_st_t;

   // Reset starts the default continuous sequence with no delay
   localparam acs_seq_st_t SEQ_RST = '{
      st:        acs_pkg::ST_DELAY,
      adc_cfg:   acs_pkg::ADC_CFG_RST,
      dly:       acs_pkg::DLY_RST,
      acc_valid: 1'b1,
      default:   '0
   };

   acs_seq_st_t s_r;
   acs_seq_st_t s_nxt;

   logic                 req;
   logic                 restart;
   logic                 kick;
   logic                 kick_dly;
   logic                 last;
   logic [2:0]           mode;
   logic [2:0]           new_mode;
   logic [3:0]           shift;
   logic [NW-1:0]        nsamp_inc;
   logic [31:0]          diag;
   logic                 tmr_load;
   logic [CW-1:0]        tmr_cnt;
   logic                 tmr_busy;
   logic                 tmr_done;
   logic                 acc_clr;
   logic [2:0]           acc_add;
   logic signed [DW-1:0] acc_avg [3];

   function automatic acs_pkg::acs_state_t first_st(input logic [2:0] m);
      if (m[acs_pkg::MODE_CUR_BIT]) begin
         first_st = acs_pkg::ST_TEMP;
      end else if (m[acs_pkg::MODE_BUS_BIT]) begin
         first_st = acs_pkg::ST_BUS;
      end else begin
         first_st = acs_pkg::ST_SHDN;
      end
   endfunction

   function automatic logic [2:0] ct_code(input acs_pkg::acs_state_t st,
                                          input logic [15:0] cfg);
      case (st)
         acs_pkg::ST_TEMP:  ct_code = cfg[acs_pkg::TMP_CT_LSB +: 3];
         acs_pkg::ST_SHUNT: ct_code = cfg[acs_pkg::SH_CT_LSB +: 3];
         default:           ct_code = cfg[acs_pkg::BUS_CT_LSB +: 3];
      endcase
   endfunction

   acs_timer #(
      .W (CW)
   ) u_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .load_i  (tmr_load),
      .count_i (tmr_cnt),
      .busy_o  (tmr_busy),
      .done_o  (tmr_done)
   );

   // Channel 0 temperature, 1 shunt, 2 bus
   for (genvar g = 0; g < 3; g++) begin : g_acc
      acs_avg #(
         .DW    (DW),
         .SUM_W (DW + 10)
      ) u_avg (
         .clk_i   (clk_i),
         .rst_i   (rst_i),
         .clr_i   (acc_clr),
         .add_i   (acc_add[g]),
         .data_i  (afe_data_i),
         .shift_i (shift),
         .avg_o   (acc_avg[g])
      );
   end

   always_comb begin
      s_nxt     = s_r;
      s_nxt.ack = 1'b0;
      restart   = 1'b0;
      kick      = 1'b0;
      kick_dly  = 1'b0;
      acc_clr   = 1'b0;
      acc_add   = 3'h0;
      tmr_load  = 1'b0;
      tmr_cnt   = '0;
      mode      = s_r.adc_cfg[acs_pkg::MODE_LSB +: 3];
      shift     = acs_pkg::avg_shift(s_r.adc_cfg[acs_pkg::AVG_LSB +: 3]);
      nsamp_inc = s_r.nsamp + NW'(1);
      last      = (nsamp_inc == (NW'(1) << shift));
      req       = wb_cyc_i && wb_stb_i && !s_r.ack;

      diag = 32'h0000_0000;
      diag[acs_pkg::DIAG_RDY_BIT]  = s_r.ready;
      diag[acs_pkg::DIAG_BUSY_BIT] = (s_r.st != acs_pkg::ST_SHDN);
      diag[acs_pkg::DIAG_ACCV_BIT] = s_r.acc_valid;

      // Bus side; a low-byte ADC_CFG write restarts the running sequence
      if (req) begin
         s_nxt.ack = 1'b1;
         if (wb_we_i) begin
            case (wb_adr_i)
               acs_pkg::OFS_ADC_CFG: begin
                  if (wb_sel_i[0]) begin
                     s_nxt.adc_cfg[7:0] = wb_dat_i[7:0];
                     restart = 1'b1;
                  end
                  if (wb_sel_i[1]) begin
                     s_nxt.adc_cfg[15:8] = wb_dat_i[15:8];
                  end
                  if (s_nxt.adc_cfg[acs_pkg::MODE_LSB +: 2] != 2'h0) begin
                     s_nxt.ready = 1'b0;
                  end
               end
               acs_pkg::OFS_DEV_CFG: begin
                  if (wb_sel_i[0]) begin
                     s_nxt.dly = wb_dat_i[7:0];
                  end
               end
               default: begin
               end
            endcase
         end else begin
            case (wb_adr_i)
               acs_pkg::OFS_ADC_CFG: s_nxt.rdat = {16'h0000, s_r.adc_cfg};
               acs_pkg::OFS_DEV_CFG: s_nxt.rdat = {24'h00_0000, s_r.dly};
               acs_pkg::OFS_DIAG:    s_nxt.rdat = diag;
               acs_pkg::OFS_TEMP:    s_nxt.rdat = {16'h0000, s_r.temp};
               acs_pkg::OFS_CURR:    s_nxt.rdat = {16'h0000, s_r.curr};
               acs_pkg::OFS_BUS:     s_nxt.rdat = {16'h0000, s_r.bus};
               acs_pkg::OFS_POWER:   s_nxt.rdat = s_r.power;
               acs_pkg::OFS_ENERGY:  s_nxt.rdat = s_r.energy;
               acs_pkg::OFS_CHARGE:  s_nxt.rdat = s_r.charge;
               default:              s_nxt.rdat = 32'h0000_0000;
            endcase
            if (wb_adr_i == acs_pkg::OFS_DIAG) begin
               s_nxt.ready = 1'b0;
            end
         end
      end

      case (s_r.st)
         acs_pkg::ST_SHDN: begin
            // Stays here until a conversion mode is written
         end
         acs_pkg::ST_DELAY: begin
            // No delay loaded means the timer is idle: start at once
            if (tmr_done || !tmr_busy) begin
               s_nxt.st = first_st(mode);
               kick     = 1'b1;
            end
         end
         acs_pkg::ST_TEMP: begin
            if (tmr_done) begin
               if (shift == 4'h0) begin
                  s_nxt.temp = afe_data_i;
               end else begin
                  acc_add[0] = 1'b1;
               end
               s_nxt.st = acs_pkg::ST_SHUNT;
               kick     = 1'b1;
            end
         end
         acs_pkg::ST_SHUNT: begin
            if (tmr_done) begin
               // Current exists only once temperature and shunt are both in
               if (shift == 4'h0) begin
                  s_nxt.curr = afe_data_i;
               end else begin
                  acc_add[1] = 1'b1;
               end
               if (mode[acs_pkg::MODE_BUS_BIT]) begin
                  s_nxt.st = acs_pkg::ST_BUS;
                  kick     = 1'b1;
               end else begin
                  s_nxt.st = acs_pkg::ST_END;
               end
            end
         end
         acs_pkg::ST_BUS: begin
            if (tmr_done) begin
               if (shift == 4'h0) begin
                  s_nxt.bus   = afe_data_i;
                  s_nxt.power = s_r.curr * $signed(afe_data_i);
               end else begin
                  acc_add[2] = 1'b1;
               end
               s_nxt.st = acs_pkg::ST_END;
            end
         end
         acs_pkg::ST_END: begin
            // One cycle of bookkeeping, no conversion time spent
            s_nxt.energy = s_r.energy + s_r.power;
            s_nxt.charge = s_r.charge + 32'(s_r.curr);
            if (last) begin
               if (shift != 4'h0) begin
                  // Results replaced only by a completed average
                  if (mode[acs_pkg::MODE_CUR_BIT]) begin
                     s_nxt.temp = acc_avg[0];
                     s_nxt.curr = acc_avg[1];
                  end
                  if (mode[acs_pkg::MODE_BUS_BIT]) begin
                     s_nxt.bus   = acc_avg[2];
                     s_nxt.power = s_r.curr * acc_avg[2];
                  end
               end
               s_nxt.ready = 1'b1;
               s_nxt.nsamp = '0;
               acc_clr     = 1'b1;
               if (mode[acs_pkg::MODE_CONT_BIT]) begin
                  s_nxt.st = first_st(mode);
                  kick     = 1'b1;
               end else begin
                  s_nxt.st = acs_pkg::ST_SHDN;
               end
            end else begin
               s_nxt.nsamp = nsamp_inc;
               s_nxt.st    = first_st(mode);
               kick        = 1'b1;
            end
         end
         default: begin
            s_nxt.st = acs_pkg::ST_SHDN;
         end
      endcase

      // A mode write overrides whatever the sequencer chose
      if (restart) begin
         new_mode        = s_nxt.adc_cfg[acs_pkg::MODE_LSB +: 3];
         kick            = 1'b0;
         acc_clr         = 1'b1;
         s_nxt.nsamp     = '0;
         s_nxt.energy    = '0;
         s_nxt.charge    = '0;
         s_nxt.acc_valid = new_mode[acs_pkg::MODE_CONT_BIT];
         if (new_mode[1:0] == 2'h0) begin
            s_nxt.st = acs_pkg::ST_SHDN;
         end else begin
            // Abort beats a completion landing in the same cycle
            s_nxt.ready = 1'b0;
            s_nxt.st    = acs_pkg::ST_DELAY;
            // Zero delay still loads one cycle, so a count left by the
            // aborted conversion cannot stretch the restart
            kick_dly    = 1'b1;
         end
      end else begin
         new_mode = mode;
      end

      if (kick_dly) begin
         tmr_load = 1'b1;
         tmr_cnt  = CW'(32'(s_r.dly) * DLY_STEP_P);
      end else if (kick) begin
         tmr_load = 1'b1;
         // Each input uses its own period
         tmr_cnt = CW'(acs_pkg::conv_us(ct_code(s_nxt.st, s_nxt.adc_cfg))
                       * CYC_PER_US_P);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= SEQ_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.rdat;

   always_comb begin
      case (s_r.st)
         acs_pkg::ST_TEMP:  afe_sel_o = acs_pkg::AFE_SEL_TEMP;
         acs_pkg::ST_SHUNT: afe_sel_o = acs_pkg::AFE_SEL_SH;
         default:           afe_sel_o = acs_pkg::AFE_SEL_BUS;
      endcase
   end

   // Filter is told the period of the running input so it settles in one
   assign afe_period_o = ct_code(s_r.st, s_r.adc_cfg);
   assign afe_run_o    = (s_r.st == acs_pkg::ST_TEMP) ||
                         (s_r.st == acs_pkg::ST_SHUNT) ||
                         (s_r.st == acs_pkg::ST_BUS);
   assign afe_shdn_o   = (s_r.st == acs_pkg::ST_SHDN);
   assign conversion_ready_flag_o = s_r.ready;
   assign acc_valid_o  = s_r.acc_valid;
endmodule

/* bench/acs_seq_properties.sv */
`timescale 1ns/1ps
module acs_seq_properties #(
   parameter int unsigned CYC_PER_US_P = acs_pkg::CYC_PER_US,
   parameter int unsigned DLY_STEP_P   = acs_pkg::DLY_STEP_CYC
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [5:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [15:0] afe_data_i,
   input wire logic [1:0]  afe_sel_o,
   input wire logic [2:0]  afe_period_o,
   input wire logic        afe_run_o,
   input wire logic        afe_shdn_o,
   input wire logic        conversion_ready_flag_o,
   input wire logic        acc_valid_o
);
   logic take;
   logic mode_wr;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign mode_wr = take & wb_we_i & (wb_adr_i == acs_pkg::OFS_ADC_CFG)
                    & wb_sel_i[0];
   a_ack_once: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ack_answer: assert property (
      take |=> wb_ack_o) else $error("request not answered");
   a_temp_first: assert property (
      afe_run_o && afe_sel_o == acs_pkg::AFE_SEL_SH
      && !($past(afe_run_o) && $past(afe_sel_o) == acs_pkg::AFE_SEL_SH)
      |-> $past(afe_run_o) && $past(afe_sel_o) == acs_pkg::AFE_SEL_TEMP)
      else $error("shunt without temperature before it");
   a_ready_end: assert property (
      $rose(conversion_ready_flag_o) |-> !$past(afe_run_o)
      && $past(afe_run_o, 2)) else $error("ready set mid sequence");
   a_cfg_clear: assert property (
      mode_wr && wb_dat_i[1:0] != 2'h0 |=> !conversion_ready_flag_o)
      else $error("ready kept after config write");
   a_diag_clear: assert property (
      take && !wb_we_i && wb_adr_i == acs_pkg::OFS_DIAG
      |=> !conversion_ready_flag_o
      || (!$past(afe_run_o) && $past(afe_run_o, 2)))
      else $error("ready kept after diag read");
   a_mode_restart: assert property (
      mode_wr |=> !afe_run_o) else $error("conversion not aborted");
   a_shdn_enter: assert property (
      mode_wr && wb_dat_i[1:0] == 2'h0 |=> afe_shdn_o && !afe_run_o)
      else $error("shutdown write ignored");
   a_shdn_quiet: assert property (
      afe_shdn_o |-> !afe_run_o && afe_sel_o == acs_pkg::AFE_SEL_BUS)
      else $error("conversion running in shutdown");
endmodule

bind acs_seq acs_seq_properties #(
   .CYC_PER_US_P(CYC_PER_US_P), .DLY_STEP_P(DLY_STEP_P)
) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .afe_data_i(afe_data_i), .afe_sel_o(afe_sel_o),
   .afe_period_o(afe_period_o), .afe_run_o(afe_run_o),
   .afe_shdn_o(afe_shdn_o), .acc_valid_o(acc_valid_o),
   .conversion_ready_flag_o(conversion_ready_flag_o)
);

/* bench/acs_afe_model.sv */
`timescale 1ns/1ps
module acs_afe_model (
   input  wire logic        clk_i,
   input  wire logic [1:0]  sel_i,
   input  wire logic        run_i,
   input  wire logic        alt_i,
   input  wire logic [15:0] temp_v_i,
   input  wire logic [15:0] sh_v_i,
   input  wire logic [15:0] bus_v_i,
   output logic      [15:0] data_o
);
   logic [2:0]  odd_r;
   logic        prun;
   logic [1:0]  psel;
   logic [15:0] base;
   initial begin
      data_o = 16'h0000;
      odd_r = 3'h0;
      prun = 1'b0;
   end
   assign base = (sel_i == 2'h0) ? temp_v_i : (sel_i == 2'h1) ? sh_v_i
                 : bus_v_i;
   always @(posedge clk_i) begin
      // Filter settled by the last cycle of every conversion
      if (run_i) begin
         data_o <= base + ((alt_i && odd_r[sel_i]) ? 16'h0002 : 16'h0000);
      end else begin
         data_o <= ~data_o; // Stale data must never pass for a sample
      end
      if (run_i && !(prun && psel == sel_i)) begin
         odd_r[sel_i] <= ~odd_r[sel_i];
      end
      prun <= run_i;
      psel <= sel_i;
   end
endmodule

/* bench/acs_seq_test.sv */
`timescale 1ns/1ps
module acs_seq_test;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, alt;
   logic [5:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rdat;
   logic        wb_ack_o, afe_run_o, afe_shdn_o, rdy, acc_valid_o, prun;
   logic [15:0] afe_data_i, temp_v, sh_v, bus_v;
   logic [1:0]  afe_sel_o, psel;
   logic [2:0]  afe_period_o, per[3];
   logic [1:0]  log_q[$];
   int          n_errors, cmp_count, cur, len[3];
   acs_seq #(.CYC_PER_US_P(1), .DLY_STEP_P(4)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .afe_data_i(afe_data_i), .afe_sel_o(afe_sel_o),
      .afe_period_o(afe_period_o), .afe_run_o(afe_run_o),
      .afe_shdn_o(afe_shdn_o), .conversion_ready_flag_o(rdy),
      .acc_valid_o(acc_valid_o));
   acs_afe_model afe (.clk_i(clk_i), .sel_i(afe_sel_o), .run_i(afe_run_o),
      .alt_i(alt), .temp_v_i(temp_v), .sh_v_i(sh_v),
      .bus_v_i(bus_v), .data_o(afe_data_i));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (afe_run_o && !(prun && psel == afe_sel_o)) begin
         log_q.push_back(afe_sel_o);
         cur = 0;
      end
      if (afe_run_o) begin
         cur++;
         len[afe_sel_o] = cur;
         per[afe_sel_o] = afe_period_o;
      end
      prun = afe_run_o;
      psel = afe_sel_o;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic we, input logic [5:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk(n, 2);
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask
   task automatic wait_for(input bit shdn, input int k);
      do begin
         @(posedge clk_i);
      end while (shdn ? afe_shdn_o !== 1'b1 : log_q.size() < k);
   endtask
   task automatic lag(input int exp);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (afe_run_o !== 1'b1);
      chk(n, exp);
   endtask
   task automatic s_reset;
      chk(32'(rdy), 32'h0);
      rdchk(acs_pkg::OFS_ADC_CFG, 32'h0b6f);
      rdchk(acs_pkg::OFS_DEV_CFG, 32'h0);
      rdchk(6'h3c, 32'h0);
   endtask
   task automatic s_trig;
      logic [1:0] exp[$];
      for (int m = 1; m <= 3; m++) begin
         bus(1'b1, acs_pkg::OFS_ADC_CFG, 32'h0440 | m);
         log_q.delete();
         exp.delete();
         wait_for(1'b1, 0);
         if (m[0]) begin
            exp.push_back(2'h0);
            exp.push_back(2'h1);
         end
         if (m[1]) begin
            exp.push_back(2'h2);
         end
         chk(log_q.size(), exp.size());
         foreach (exp[i]) chk(32'(log_q[i]), 32'(exp[i]));
         rdchk(acs_pkg::OFS_DIAG, 32'h1);
         rdchk(acs_pkg::OFS_DIAG, 32'h0);
      end
      chk(len[0], 150);
      chk(len[1], 84);
      chk(len[2], 50);
      chk(32'(per[0]), 32'h2);
      chk(32'(per[1]), 32'h1);
      chk(32'(per[2]), 32'h0);
      rdchk(acs_pkg::OFS_TEMP, 32'h1234);
      rdchk(acs_pkg::OFS_CURR, 32'hfff0);
      rdchk(acs_pkg::OFS_BUS, 32'h0456);
   endtask
   task automatic s_avg;
      alt <= 1'b1;
      bus(1'b1, acs_pkg::OFS_ADC_CFG, 32'h1002);
      log_q.delete();
      wait_for(1'b1, 0);
      chk(log_q.size(), 4);
      rdchk(acs_pkg::OFS_BUS, 32'h0457);
      rdchk(acs_pkg::OFS_TEMP, 32'h1234);
      rdchk(acs_pkg::OFS_DIAG, 32'h1);
      alt <= 1'b0;
   endtask
   task automatic s_cont;
      bus(1'b1, acs_pkg::OFS_DEV_CFG, 32'h2);
      bus(1'b1, acs_pkg::OFS_ADC_CFG, 32'h0007);
      log_q.delete();
      lag(8);
      wait_for(1'b0, 7);
      for (int i = 0; i < 6; i++) chk(32'(log_q[i]), 32'(i % 3));
      rdchk(acs_pkg::OFS_DIAG, 32'h7);
      bus(1'b1, acs_pkg::OFS_ADC_CFG, 32'h0007);
      chk(32'(rdy), 32'h0);
      lag(8);
      bus(1'b1, acs_pkg::OFS_ADC_CFG, 32'h0003);
      chk(32'(acc_valid_o), 32'h0);
      bus(1'b1, acs_pkg::OFS_ADC_CFG, 32'h0000);
      log_q.delete();
      repeat (300) @(posedge clk_i);
      chk(log_q.size(), 0);
      bus(1'b1, acs_pkg::OFS_DEV_CFG, 32'h5a);
      rdchk(acs_pkg::OFS_DEV_CFG, 32'h5a);
   endtask
   task automatic close_out;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #(40 * 60000);
      n_errors++;
      close_out();
   end
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, alt, prun} = 6'h20;
      {wb_adr_i, wb_sel_i, wb_dat_i} = {6'h0, 4'hf, 32'h0};
      {temp_v, sh_v, bus_v} = {16'h1234, 16'hfff0, 16'h0456};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      s_reset();
      s_trig();
      s_avg();
      s_cont();
      close_out();
   end
endmodule
